// ===== rtl/hotplug_cfg_pkg.sv
// Package for the hot-plug signal configuration block.
// Assumes a single 200 MHz core clock and a simple word register port.
package hotplug_cfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] HOTPLUG_CONFIG_CONTROL_OFS = 12'h408;
  localparam logic [31:0] HOTPLUG_CONFIG_CONTROL_RST = 32'h0000_0800;
  // Writable bits: 0..8, reserved 10:9 (RW), 11..13
  localparam logic [31:0] HOTPLUG_CONFIG_CONTROL_MASK = 32'h0000_3fff;

  // ==========================================================
  // Field positions
  localparam int INVERT_ATTN_BUTTON_POL_BIT     = 0;
  localparam int INVERT_PRESENCE_POL_BIT        = 1;
  localparam int INVERT_POWER_FAULT_POL_BIT     = 2;
  localparam int INVERT_LATCH_SENSOR_POL_BIT    = 3;
  localparam int INVERT_ATTN_INDICATOR_POL_BIT  = 4;
  localparam int INVERT_POWER_INDICATOR_POL_BIT = 5;
  localparam int INVERT_POWER_ENABLE_POL_BIT    = 6;
  localparam int INVERT_INTERLOCK_POL_BIT       = 7;
  localparam int INVERT_POWER_GOOD_POL_BIT      = 8;
  localparam int LATCH_OPEN_AUTO_POWER_OFF_BIT  = 11;
  localparam int LATCH_INPUT_AS_LOCK_STATE_BIT  = 12;
  localparam int INTERLOCK_TOGGLE_MODE_BIT      = 13;

  // ==========================================================
  // Timing
  localparam longint CLK_FREQ_HZ          = 200_000_000;
  localparam longint INTERLOCK_PULSE_US   = 125_000;
  localparam longint INTERLOCK_PULSE_CYC  = (INTERLOCK_PULSE_US * CLK_FREQ_HZ) / 1_000_000;

  // ==========================================================
  // Per-port pin bundles
  typedef struct packed {
    logic attnButton;
    logic presence;
    logic powerFault;
    logic latchSensor;
    logic powerGood;
  } slot_in_t;

  typedef struct packed {
    logic attnIndicator;
    logic powerIndicator;
    logic powerEnable;
  } slot_ctl_t;

  typedef enum logic [1:0] {
    LOCK_IDLE   = 2'b00,
    LOCK_PULSE  = 2'b01,
    LOCK_TOGGLE = 2'b10
  } lock_state_t;

endpackage

// ===== rtl/hotplug_signal_config.sv
// Hot-plug signal configuration for all downstream ports of the switch.
// Assumes slot pins arrive asynchronously and slot logic runs on clk.
`timescale 1ns/1ps

module hotplug_signal_config
  import hotplug_cfg_pkg::*;
#(
  parameter int     PORTS     = 8,
  parameter longint PULSE_CYC = INTERLOCK_PULSE_CYC
) (
  // Clock and fundamental reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Register port
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [11:0]           regAddr,
  input  wire logic [31:0]           regWdata,
  output logic      [31:0]           regRdata,
  // Hot-plug slot pins, raw levels
  input  wire logic [PORTS-1:0]      attn_button_n,
  input  wire logic [PORTS-1:0]      presence_detect_n,
  input  wire logic [PORTS-1:0]      power_fault_n,
  input  wire logic [PORTS-1:0]      latch_sensor_n,
  input  wire logic [PORTS-1:0]      slot_power_good_n,
  output logic      [PORTS-1:0]      attn_indicator_n,
  output logic      [PORTS-1:0]      power_indicator_n,
  output logic      [PORTS-1:0]      slot_power_enable,
  output logic      [PORTS-1:0]      interlock_drive,
  // Slot controller side, active high
  input  wire logic                  latch_present_cap,
  input  wire slot_ctl_t [PORTS-1:0] slotCtl,
  input  wire logic [PORTS-1:0]      interlock_ctl_write,
  output slot_in_t  [PORTS-1:0]      slotStatus,
  output logic      [PORTS-1:0]      retention_latch_open,
  output logic      [PORTS-1:0]      electromech_lock_engaged
);

  // ==========================================================
  // Configuration register
  // Only rst_b resets it, to 32'h0000_0800; hot reset does not reach this block at all
  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic [31:0] next_regRdata;
  logic        hitCfg;

  assign hitCfg = (regAddr == HOTPLUG_CONFIG_CONTROL_OFS);

  always_comb begin
    next_cfg = cfg;
    if (regWrite && hitCfg) begin
      next_cfg = regWdata & HOTPLUG_CONFIG_CONTROL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= HOTPLUG_CONFIG_CONTROL_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Read path
  // Other addresses read as zero rather than echoing the config word
  always_comb begin
    next_regRdata = 32'h0000_0000;
    if (regRead && hitCfg) begin
      next_regRdata = cfg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  // ==========================================================
  // Field decode, shared by every port
  // Decoded once so every port reads the same named mode bits
  logic invAttnButton;
  logic invPresence;
  logic invPowerFault;
  logic invLatchSensor;
  logic invAttnIndicator;
  logic invPowerIndicator;
  logic invPowerEnable;
  logic invInterlock;
  logic invPowerGood;
  logic autoPowerOff;
  logic latchAsLock;
  logic toggleMode;

  assign invAttnButton     = cfg[INVERT_ATTN_BUTTON_POL_BIT];
  assign invPresence       = cfg[INVERT_PRESENCE_POL_BIT];
  assign invPowerFault     = cfg[INVERT_POWER_FAULT_POL_BIT];
  assign invLatchSensor    = cfg[INVERT_LATCH_SENSOR_POL_BIT];
  assign invAttnIndicator  = cfg[INVERT_ATTN_INDICATOR_POL_BIT];
  assign invPowerIndicator = cfg[INVERT_POWER_INDICATOR_POL_BIT];
  assign invPowerEnable    = cfg[INVERT_POWER_ENABLE_POL_BIT];
  assign invInterlock      = cfg[INVERT_INTERLOCK_POL_BIT];
  assign invPowerGood      = cfg[INVERT_POWER_GOOD_POL_BIT];
  assign autoPowerOff      = cfg[LATCH_OPEN_AUTO_POWER_OFF_BIT];
  assign latchAsLock       = cfg[LATCH_INPUT_AS_LOCK_STATE_BIT];
  assign toggleMode        = cfg[INTERLOCK_TOGGLE_MODE_BIT];

  // ==========================================================
  // Input synchronisers: five pins per port, two stages each
  slot_in_t [PORTS-1:0] syncA;
  slot_in_t [PORTS-1:0] syncB;
  slot_in_t [PORTS-1:0] next_syncA;

  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      next_syncA[p] = '{attnButton:  attn_button_n[p],
                        presence:    presence_detect_n[p],
                        powerFault:  power_fault_n[p],
                        latchSensor: latch_sensor_n[p],
                        powerGood:   slot_power_good_n[p]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Idle pin level, so no false event is reported after reset
      syncA <= '1;
      syncB <= '1;
    end else begin
      syncA <= next_syncA;
      syncB <= syncA;
    end
  end

  // ==========================================================
  // Per-port logic
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : gPort
      // Status group
      slot_in_t    sensed;
      slot_in_t    next_status;
      logic        latchOpen;
      logic        lockEngaged;
      logic        next_latchOpen;
      logic        next_lockEng;

      // Drive group
      logic        autoOff;
      logic        powerOn;
      logic        next_attn;
      logic        next_pind;
      logic        next_pwr;

      // Interlock group
      logic        lockLevel;
      logic        next_lockLevel;
      logic [31:0] pulseCnt;
      logic [31:0] next_pulseCnt;
      lock_state_t lockState;
      lock_state_t next_lockState;
      logic        next_ilock;

      // ========================================================
      // Sensed status
      // Pins are active low; a set invert bit flips the sense
      always_comb begin
        sensed.attnButton  = ~(syncB[g].attnButton ^ invAttnButton);
        sensed.presence    = ~(syncB[g].presence ^ invPresence);
        sensed.powerFault  = ~(syncB[g].powerFault ^ invPowerFault);
        sensed.latchSensor = ~(syncB[g].latchSensor ^ invLatchSensor);
        sensed.powerGood   = ~(syncB[g].powerGood ^ invPowerGood);
        // Asserted latch sensor means latch open, or lock engaged in lock mode
        latchOpen      = sensed.latchSensor & ~latchAsLock;
        lockEngaged    = sensed.latchSensor & latchAsLock;
        next_status    = sensed;
        next_status.latchSensor = latchOpen;
        next_latchOpen = latchOpen;
        next_lockEng   = lockEngaged;
      end

      // Status is registered so the controller sees one settled value
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          slotStatus[g]               <= '0;
          retention_latch_open[g]     <= 1'b0;
          electromech_lock_engaged[g] <= 1'b0;
        end else begin
          slotStatus[g]               <= next_status;
          retention_latch_open[g]     <= next_latchOpen;
          electromech_lock_engaged[g] <= next_lockEng;
        end
      end

      // ========================================================
      // Indicator and slot power drive
      // With autoPowerOff and latch_present_cap set, latch open overrides whatever software asks of the power controller
      // Power drops on the first sample that reads open; there is no debounce
      always_comb begin
        autoOff   = autoPowerOff & latch_present_cap & latchOpen;
        powerOn   = slotCtl[g].powerEnable & ~autoOff;
        next_attn = ~(slotCtl[g].attnIndicator ^ invAttnIndicator);
        next_pind = ~(slotCtl[g].powerIndicator ^ invPowerIndicator);
        next_pwr  = powerOn ^ invPowerEnable;
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          attn_indicator_n[g]  <= 1'b1;
          power_indicator_n[g] <= 1'b1;
          slot_power_enable[g] <= 1'b0;
        end else begin
          attn_indicator_n[g]  <= next_attn;
          power_indicator_n[g] <= next_pind;
          slot_power_enable[g] <= next_pwr;
        end
      end

      // ========================================================
      // Interlock
      // Pulse or toggle on each control write made while no pulse is running
      // A 32-bit counter covers the pulse at any plausible core clock
      always_comb begin
        next_lockState = lockState;
        next_lockLevel = lockLevel;
        next_pulseCnt  = pulseCnt;
        unique case (lockState)
          LOCK_IDLE: begin
            if (interlock_ctl_write[g]) begin
              if (toggleMode) begin
                next_lockLevel = ~lockLevel;
                next_lockState = LOCK_TOGGLE;
              end else begin
                next_lockLevel = 1'b1;
                next_pulseCnt  = 32'(PULSE_CYC - 1);
                next_lockState = LOCK_PULSE;
              end
            end
          end
          LOCK_PULSE: begin
            // Writes during a pulse are ignored; the pulse is not stretched
            if (pulseCnt == 32'h0000_0000) begin
              next_lockLevel = 1'b0;
              next_lockState = LOCK_IDLE;
            end else begin
              next_pulseCnt = pulseCnt - 32'h0000_0001;
            end
          end
          LOCK_TOGGLE: begin
            // Leaving toggle mode drops the interlock so a later pulse starts low
            if (interlock_ctl_write[g] && toggleMode) begin
              next_lockLevel = ~lockLevel;
            end else if (!toggleMode) begin
              next_lockLevel = 1'b0;
              next_lockState = LOCK_IDLE;
            end
          end
          default: begin
            next_lockState = LOCK_IDLE;
            next_lockLevel = 1'b0;
          end
        endcase
        next_ilock = next_lockLevel ^ invInterlock;
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          lockState          <= LOCK_IDLE;
          lockLevel          <= 1'b0;
          pulseCnt           <= 32'h0000_0000;
          interlock_drive[g] <= 1'b0;
        end else begin
          lockState          <= next_lockState;
          lockLevel          <= next_lockLevel;
          pulseCnt           <= next_pulseCnt;
          interlock_drive[g] <= next_ilock;
        end
      end
    end
  endgenerate

endmodule // hotplug_signal_config

// ===== tb/hotplug_signal_config_checker.sv
// Assertion checker for the hot-plug signal configuration block.
// Assumes it is bound to the block and sees only the block's ports.
`timescale 1ns/1ps
module hotplug_signal_config_checker
  import hotplug_cfg_pkg::*;
#(parameter int PORTS = 8, parameter longint PULSE_CYC = 10) (
  // Clock, reset and register port
  input wire logic clk, rst_b, regWrite, regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata, regRdata,
  // Slot pins
  input wire logic [PORTS-1:0] attn_button_n, presence_detect_n, power_fault_n,
  input wire logic [PORTS-1:0] latch_sensor_n, slot_power_good_n, attn_indicator_n,
  input wire logic [PORTS-1:0] power_indicator_n, slot_power_enable, interlock_drive,
  // Slot controller side
  input wire logic latch_present_cap,
  input wire slot_ctl_t [PORTS-1:0] slotCtl,
  input wire logic [PORTS-1:0] interlock_ctl_write, retention_latch_open,
  input wire slot_in_t [PORTS-1:0] slotStatus,
  input wire logic [PORTS-1:0] electromech_lock_engaged
);
  // ==========
  // Config mirror; pin paths are judged only after config has been quiet a while
  logic [31:0] cfg;
  logic [2:0]  quiet;
  logic [31:0] hiLen;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg   <= HOTPLUG_CONFIG_CONTROL_RST;
      quiet <= 3'h0;
      hiLen <= 32'h0;
    end else begin
      if (regWrite && regAddr == HOTPLUG_CONFIG_CONTROL_OFS)
        cfg <= regWdata & HOTPLUG_CONFIG_CONTROL_MASK;
      quiet <= regWrite ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      hiLen <= interlock_drive[0] ? hiLen + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_read;
    regRdata == ($past(regRead && regAddr == HOTPLUG_CONFIG_CONTROL_OFS) ? $past(cfg) : 32'h0);
  endproperty
  property p_ind; quiet != 3'h0 |->
    attn_indicator_n[0] == $past(!slotCtl[0].attnIndicator ^ cfg[4]); endproperty
  property p_btn; $stable(attn_button_n[0])[*4] ##0 quiet > 3'h4 |->
    slotStatus[0].attnButton == (!attn_button_n[0] ^ cfg[0]); endproperty
  property p_pres; $stable(presence_detect_n[0])[*4] ##0 quiet > 3'h4 |->
    slotStatus[0].presence == (!presence_detect_n[0] ^ cfg[1]); endproperty
  property p_off; $stable({latch_sensor_n[0], latch_present_cap})[*4] ##0 quiet > 3'h4
    && cfg[11] && !cfg[12] && latch_present_cap && (!latch_sensor_n[0] ^ cfg[3])
    |-> slot_power_enable[0] == cfg[6]; endproperty
  property p_lock; $stable(latch_sensor_n[0])[*4] ##0 quiet > 3'h4 && cfg[12] |->
    !retention_latch_open[0]
    && electromech_lock_engaged[0] == (!latch_sensor_n[0] ^ cfg[3]); endproperty
  property p_pstart; interlock_ctl_write[0] && !cfg[13] && !cfg[7] && !interlock_drive[0]
    && quiet > 3'h1 |-> ##[1:2] interlock_drive[0]; endproperty
  property p_plen; $fell(interlock_drive[0]) && !cfg[13] && !cfg[7] && quiet > 3'h4
    |-> hiLen == PULSE_CYC; endproperty
  property p_tog; interlock_ctl_write[0] && cfg[13] && quiet > 3'h1
    |-> ##[1:2] $changed(interlock_drive[0]); endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  a_ind: assert property (p_ind) else $error("indicator level wrong");
  a_btn: assert property (p_btn) else $error("button state wrong");
  a_pres: assert property (p_pres) else $error("presence state wrong");
  a_off: assert property (p_off) else $error("power not removed");
  a_lock: assert property (p_lock) else $error("lock state wrong");
  a_pstart: assert property (p_pstart) else $error("pulse missing");
  a_plen: assert property (p_plen) else $error("pulse length wrong");
  a_tog: assert property (p_tog) else $error("toggle missing");
  c_tog: cover property (interlock_ctl_write[0] && cfg[13]);
  c_off: cover property ($fell(slot_power_enable[0]));
  c_read: cover property (regRead && regAddr == HOTPLUG_CONFIG_CONTROL_OFS);
endmodule // hotplug_signal_config_checker
bind hotplug_signal_config hotplug_signal_config_checker
  #(.PORTS(PORTS), .PULSE_CYC(PULSE_CYC)) i_chk (.*);

// ===== tb/hotplug_slot_model.sv
// Behavioural slot: buttons and sensors that pull their lines low.
// Assumes the bench sets slot events active high.
`timescale 1ns/1ps
module hotplug_slot_model #(parameter int PORTS = 2) (
  // Slot events, active high
  input  wire logic [PORTS-1:0] button, present, fault, latchOpen, pgood,
  // Sensor lines toward the switch
  output logic [PORTS-1:0] attn_button_n, presence_detect_n, power_fault_n,
  output logic [PORTS-1:0] latch_sensor_n, slot_power_good_n
);
  // Open-collector sensors, so an asserted event reads low
  always_comb begin
    attn_button_n     = ~button;
    presence_detect_n = ~present;
    power_fault_n     = ~fault;
    latch_sensor_n    = ~latchOpen;
    slot_power_good_n = ~pgood;
  end
endmodule // hotplug_slot_model

// ===== tb/tb.sv
// Self-checking bench for the hot-plug signal configuration block.
// Assumes a short interlock pulse count so the run stays brief.
`timescale 1ns/1ps
module tb;
  import hotplug_cfg_pkg::*;
  localparam int PORTS = 2;
  localparam longint PULSE_CYC = 10;
  logic clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0, latch_present_cap = 1'b0;
  logic [11:0] regAddr = '0;
  logic [31:0] regWdata = '0, regRdata;
  logic [PORTS-1:0] button = '0, present = '0, fault = '0, latchOpen = '0, pgood = '0;
  logic [PORTS-1:0] attn_button_n, presence_detect_n, power_fault_n, latch_sensor_n;
  logic [PORTS-1:0] slot_power_good_n, attn_indicator_n, power_indicator_n, slot_power_enable;
  logic [PORTS-1:0] interlock_drive, interlock_ctl_write = '0, retention_latch_open;
  logic [PORTS-1:0] electromech_lock_engaged;
  logic [3:0] driveSeen;
  slot_ctl_t [PORTS-1:0] slotCtl = '0;
  slot_in_t [PORTS-1:0] slotStatus;
  int fails = 0, samples_checked = 0, cyc = 0, n = 0;
  int inBit[5] = '{0, 1, 2, 3, 8};
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); end end
  hotplug_signal_config #(.PORTS(PORTS), .PULSE_CYC(PULSE_CYC)) i_dut (.clk, .rst_b,
    .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .attn_button_n, .presence_detect_n,
    .power_fault_n, .latch_sensor_n, .slot_power_good_n, .attn_indicator_n, .power_indicator_n,
    .slot_power_enable, .interlock_drive, .latch_present_cap, .slotCtl, .interlock_ctl_write,
    .slotStatus, .retention_latch_open, .electromech_lock_engaged);
  hotplug_slot_model #(.PORTS(PORTS)) i_slot (.button, .present, .fault, .latchOpen, .pgood,
    .attn_button_n, .presence_detect_n, .power_fault_n, .latch_sensor_n, .slot_power_good_n);
  always #2.5 clk = ~clk;
  // Whole run is about 230 cycles, so this ceiling only cuts a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin fails++; print_verdict(); end
  end
  // ==========
  // Access tasks, driven at the falling edge
  task automatic settle; repeat (4) @(negedge clk); endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk); regWrite = 1'b1; regAddr = a; regWdata = d;
    @(negedge clk); regWrite = 1'b0;
    settle();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge clk); regRead = 1'b1; regAddr = a;
    @(negedge clk); regRead = 1'b0;
    `CHK(regRdata, e)
  endtask
  // Counts interlock high time across its own cycles too
  task automatic ilock;
    @(negedge clk); n += interlock_drive[0]; interlock_ctl_write = 2'b01;
    @(negedge clk); n += interlock_drive[0]; interlock_ctl_write = 2'b00;
  endtask
  task automatic done(input int t); $display("Test %0d finished", t); endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(12'h408, 32'h0000_0800);
    wr(12'h40c, 32'hffff_ffff);
    rd(12'h40c, 32'h0);
    rd(12'h408, 32'h0000_0800);
    wr(12'h408, 32'hffff_ffff);
    rd(12'h408, 32'h0000_3fff);
    done(1);
    {button, present, fault, latchOpen, pgood} = '1;
    wr(12'h408, 32'h0);
    `CHK(slotStatus[1], 5'h1f)
    for (int k = 0; k < 5; k++) begin
      wr(12'h408, 32'h1 << inBit[k]);
      `CHK(slotStatus[1], 5'h1f ^ (5'h10 >> k))
    end
    done(2);
    latchOpen = '0;
    slotCtl = '1;
    for (int k = 0; k < 5; k++) begin
      wr(12'h408, k == 0 ? 32'h0 : 32'h8 << k);
      driveSeen = {attn_indicator_n[0], power_indicator_n[0],
                   slot_power_enable[0], interlock_drive[0]};
      `CHK(driveSeen, {k == 1, k == 2, k != 3, k == 4})
    end
    done(3);
    latch_present_cap = 1'b1;
    latchOpen = 2'b01;
    wr(12'h408, 32'h800);
    `CHK({slot_power_enable, retention_latch_open}, 4'b1001)
    latch_present_cap = 1'b0;
    settle();
    `CHK(slot_power_enable, 2'b11)
    latch_present_cap = 1'b1;
    wr(12'h408, 32'h1800);
    `CHK({slot_power_enable, retention_latch_open, electromech_lock_engaged}, 6'b110001)
    done(4);
    wr(12'h408, 32'h0);
    n = 0;
    ilock();
    repeat (3) begin @(negedge clk); n += interlock_drive[0]; end
    ilock();
    repeat (30) begin @(negedge clk); n += interlock_drive[0]; end
    `CHK(n, PULSE_CYC)
    done(5);
    wr(12'h408, 32'h2000);
    ilock();
    settle();
    `CHK(interlock_drive, 2'b01)
    ilock();
    settle();
    `CHK(interlock_drive, 2'b00)
    ilock();
    settle();
    `CHK(interlock_drive, 2'b01)
    done(6);
    wr(12'h408, 32'h1234);
    `CHK(interlock_drive, 2'b00)
    repeat (50) @(negedge clk);
    rd(12'h408, 32'h0000_1234);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(12'h408, 32'h0000_0800);
    done(7);
    print_verdict();
  end
endmodule // tb
